// ---- lams_pkg.sv ----
// Purpose: Shared constants for the aggregated port group member selector
// Assumes: Single clock domain, synchronous active-high reset
// Notes: Frame word layout is shared by the selector and its input FIFO
package lams_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_PORTS = 28;
  localparam int NUM_GROUPS = 5;
  localparam int MAX_MEMBERS = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int PORT_W = 5;
  localparam int GRP_W = 3;
  localparam int SPD_W = 2;
  localparam int CNT_W = 4;
  localparam int HASH_W = 8;
  localparam int TAG_W = 8;
  localparam int HEN_W = 4;

  // ****************************************
  // Hash contributor enables
  // ****************************************
  localparam int HEN_SMAC = 0;
  localparam int HEN_DMAC = 1;
  localparam int HEN_IP = 2;
  localparam int HEN_L4 = 3;
  localparam logic [HEN_W-1:0] HASH_EN_RST = 4'hd;

  // ****************************************
  // Frame word layout
  // ****************************************
  localparam int F_SMAC = 0;
  localparam int F_DMAC = 48;
  localparam int F_SIP = 96;
  localparam int F_DIP = 128;
  localparam int F_SL4 = 160;
  localparam int F_DL4 = 176;
  localparam int F_IPV4 = 192;
  localparam int F_L4 = 193;
  localparam int F_DPORT = 194;
  localparam int F_DGRP = 199;
  localparam int F_TAG = 202;
  localparam int WORD_W = 210;
endpackage

// ---- lams_fifo.sv ----
// Purpose: Synchronous FIFO in front of the member selector
// Assumes: Single clock, synchronous active-high reset
// Notes: Full and empty are registered so ready and valid come from flops
`timescale 1ns/10ps
module lams_fifo #(
  parameter int WIDTH = lams_pkg::WORD_W,
  parameter int DEPTH = lams_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // ****************************************
  // Pointers and level
  // ****************************************
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ---- lams_top.sv ----
// Purpose: Picks the egress member port of an aggregated port group per frame
// Assumes: Configuration inputs are quasi-static; single 10 MHz clock
// Notes: Membership state lags configuration by one clock
`timescale 1ns/10ps
// Function
// R01: All frames of one flow leave through the same member port.
// R02: Hash uses MACs, IPv4 addresses and L4 ports, only enabled contributors.
// R03: Source MAC contributor has its own enable, set after reset.
// R04: Destination MAC contributor has its own enable, cleared after reset.
// R05: IP address contributor has its own enable, set after reset.
// R06: TCP/UDP port contributor has its own enable, set after reset.
// R07: One contributor enable set is shared by every group.
// R08: A group accepts at most ten member ports.
// R09: No more than five groups exist at once.
// R10: A port belongs to at most one group.
// R11: Group members may not be mirror source or mirror destination.
// R12: Negotiated group puts surplus members on standby, promotes one on failure.
// R13: Only full duplex ports at the group speed are aggregated.
// R14: A group acts as one logical port with one speed and duplex.
// R15: Negotiated group forms only when partner ports run the protocol too.
// R16: Spanning tree and VLAN membership apply to the whole group.
// R17: Hash maps only onto currently active members.
module lams_top #(
  parameter int NP = lams_pkg::NUM_PORTS,
  parameter int NG = lams_pkg::NUM_GROUPS,
  parameter int MAXM = lams_pkg::MAX_MEMBERS,
  parameter int DEPTH = lams_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hash_cfg_we,
  input wire logic [lams_pkg::HEN_W-1:0] hash_cfg_data,
  output logic [lams_pkg::HEN_W-1:0] hash_en,
  input wire logic [NP*lams_pkg::GRP_W-1:0] port_grp_cfg,
  input wire logic [NG-1:0] grp_lacp_cfg,
  input wire logic [NG*lams_pkg::CNT_W-1:0] grp_max_active_cfg,
  input wire logic [NG*lams_pkg::SPD_W-1:0] grp_speed_cfg,
  input wire logic [NP-1:0] port_link_up,
  input wire logic [NP-1:0] port_full_duplex,
  input wire logic [NP*lams_pkg::SPD_W-1:0] port_speed,
  input wire logic [NP-1:0] partner_lacp,
  input wire logic [NP-1:0] mirror_src_req,
  input wire logic [NP-1:0] mirror_dst_req,
  input wire logic [NG-1:0] grp_stp_fwd,
  input wire logic [NP-1:0] port_stp_fwd_cfg,
  input wire logic [NG-1:0] grp_vlan_member,
  input wire logic [NP-1:0] port_vlan_member_cfg,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [47:0] in_smac,
  input wire logic [47:0] in_dmac,
  input wire logic [31:0] in_sip,
  input wire logic [31:0] in_dip,
  input wire logic [15:0] in_sl4,
  input wire logic [15:0] in_dl4,
  input wire logic in_is_ipv4,
  input wire logic in_is_l4,
  input wire logic [lams_pkg::PORT_W-1:0] in_dst_port,
  input wire logic [lams_pkg::GRP_W-1:0] in_dst_grp,
  input wire logic [lams_pkg::TAG_W-1:0] in_tag,
  output logic out_valid,
  input wire logic out_ready,
  output logic [lams_pkg::PORT_W-1:0] out_port,
  output logic out_drop,
  output logic [lams_pkg::TAG_W-1:0] out_tag,
  output logic [NP-1:0] member_mask,
  output logic [NP-1:0] member_active,
  output logic [NP-1:0] member_standby,
  output logic [NG-1:0] grp_up,
  output logic [NP-1:0] mirror_src_en,
  output logic [NP-1:0] mirror_dst_en,
  output logic [NP-1:0] port_stp_fwd,
  output logic [NP-1:0] port_vlan_member
);
  localparam int GW = lams_pkg::GRP_W;
  localparam int CW = lams_pkg::CNT_W;
  localparam int SW = lams_pkg::SPD_W;

  logic [lams_pkg::HEN_W-1:0] next_hash_en;
  logic [NG*NP-1:0] mem_q;
  logic [NG*NP-1:0] act_q;
  logic [NG*CW-1:0] acnt_q;
  logic [NG*NP-1:0] next_mem;
  logic [NG*NP-1:0] next_act;
  logic [NG*CW-1:0] next_acnt;
  logic [NP-1:0] next_member_mask;
  logic [NP-1:0] next_member_active;
  logic [NP-1:0] next_stp;
  logic [NP-1:0] next_vlan;
  logic [lams_pkg::WORD_W-1:0] fifo_in;
  logic [lams_pkg::WORD_W-1:0] head;
  logic head_valid;
  logic load_ev;
  logic [15:0] h16;
  logic [lams_pkg::HASH_W-1:0] cur_hash;
  logic [NP-1:0] grp_act;
  logic [CW-1:0] grp_cnt;
  logic [lams_pkg::HASH_W+CW-1:0] prod;
  logic [CW-1:0] pick_idx;
  logic [CW-1:0] walk;
  logic [lams_pkg::PORT_W-1:0] sel_port;
  logic sel_drop;
  logic next_out_valid;
  logic [lams_pkg::PORT_W-1:0] next_out_port;
  logic next_out_drop;
  logic [lams_pkg::TAG_W-1:0] next_out_tag;

  // ****************************************
  // Hash contributor enables
  // ****************************************
  // R07 single global set
  always_comb begin
    next_hash_en = hash_en;
    if (hash_cfg_we) begin
      next_hash_en = hash_cfg_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // R03 R04 R05 R06 reset defaults
      hash_en <= lams_pkg::HASH_EN_RST;
    end else begin
      hash_en <= next_hash_en;
    end
  end

  // ****************************************
  // Membership and active set
  // ****************************************
  always_comb begin
    logic [CW-1:0] mcnt;
    logic [CW-1:0] acnt;
    logic [CW-1:0] cap;
    logic elig;
    mcnt = '0;
    acnt = '0;
    cap = '0;
    elig = 1'b0;
    next_mem = '0;
    next_act = '0;
    next_acnt = '0;
    for (int g = 0; g < NG; g++) begin
      mcnt = '0;
      acnt = '0;
      // R12 standby cap for negotiated groups
      cap = grp_lacp_cfg[g] ? grp_max_active_cfg[g*CW +: CW] : CW'(MAXM);
      for (int p = 0; p < NP; p++) begin
        // R09 R10 one group id per port, ids above five never match
        // R08 ten member ceiling
        if (port_grp_cfg[p*GW +: GW] == GW'(g + 1) && mcnt < CW'(MAXM)) begin
          next_mem[g*NP + p] = 1'b1;
          mcnt = mcnt + 1'b1;
          // R13 R14 same speed, full duplex
          // R15 partner must negotiate too
          elig = port_link_up[p] && port_full_duplex[p] && port_speed[p*SW +: SW] == grp_speed_cfg[g*SW +: SW]
                 && (!grp_lacp_cfg[g] || partner_lacp[p]);
          if (elig && acnt < cap) begin
            next_act[g*NP + p] = 1'b1;
            acnt = acnt + 1'b1;
          end
        end
      end
      next_acnt[g*CW +: CW] = acnt;
    end
  end

  always_comb begin
    next_member_mask = '0;
    next_member_active = '0;
    next_stp = port_stp_fwd_cfg;
    next_vlan = port_vlan_member_cfg;
    for (int p = 0; p < NP; p++) begin
      for (int g = 0; g < NG; g++) begin
        if (next_mem[g*NP + p]) begin
          next_member_mask[p] = 1'b1;
          next_member_active[p] = next_act[g*NP + p];
          // R16 group-wide STP and VLAN
          next_stp[p] = grp_stp_fwd[g];
          next_vlan[p] = grp_vlan_member[g];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_q <= '0;
      act_q <= '0;
      acnt_q <= '0;
      member_mask <= '0;
      member_active <= '0;
      member_standby <= '0;
      grp_up <= '0;
      mirror_src_en <= '0;
      mirror_dst_en <= '0;
      port_stp_fwd <= '0;
      port_vlan_member <= '0;
    end else begin
      mem_q <= next_mem;
      act_q <= next_act;
      acnt_q <= next_acnt;
      member_mask <= next_member_mask;
      member_active <= next_member_active;
      member_standby <= next_member_mask & ~next_member_active;
      for (int g = 0; g < NG; g++) begin
        grp_up[g] <= next_acnt[g*CW +: CW] != '0;
      end
      // R11 members never mirror
      mirror_src_en <= mirror_src_req & ~next_member_mask;
      mirror_dst_en <= mirror_dst_req & ~next_member_mask;
      port_stp_fwd <= next_stp;
      port_vlan_member <= next_vlan;
    end
  end

  // ****************************************
  // Frame buffer
  // ****************************************
  assign fifo_in = {in_tag, in_dst_grp, in_dst_port, in_is_l4, in_is_ipv4, in_dl4, in_sl4, in_dip, in_sip, in_dmac, in_smac};

  lams_fifo #(
    .WIDTH(lams_pkg::WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(fifo_in),
    .out_valid(head_valid),
    .out_ready(!out_valid || out_ready),
    .out_data(head)
  );

  assign load_ev = head_valid && (!out_valid || out_ready);

  // ****************************************
  // Flow hash and member pick
  // ****************************************
  always_comb begin
    h16 = '0;
    // R02 gated contributors
    if (hash_en[lams_pkg::HEN_SMAC]) begin
      h16 = h16 ^ head[lams_pkg::F_SMAC +: 16] ^ head[lams_pkg::F_SMAC+16 +: 16] ^ head[lams_pkg::F_SMAC+32 +: 16];
    end
    if (hash_en[lams_pkg::HEN_DMAC]) begin
      h16 = h16 ^ head[lams_pkg::F_DMAC +: 16] ^ head[lams_pkg::F_DMAC+16 +: 16] ^ head[lams_pkg::F_DMAC+32 +: 16];
    end
    if (hash_en[lams_pkg::HEN_IP] && head[lams_pkg::F_IPV4]) begin
      h16 = h16 ^ head[lams_pkg::F_SIP +: 16] ^ head[lams_pkg::F_SIP+16 +: 16];
      h16 = h16 ^ head[lams_pkg::F_DIP +: 16] ^ head[lams_pkg::F_DIP+16 +: 16];
    end
    if (hash_en[lams_pkg::HEN_L4] && head[lams_pkg::F_IPV4] && head[lams_pkg::F_L4]) begin
      h16 = h16 ^ head[lams_pkg::F_SL4 +: 16] ^ head[lams_pkg::F_DL4 +: 16];
    end
    cur_hash = h16[15:8] ^ h16[7:0];
  end

  always_comb begin
    grp_act = '0;
    grp_cnt = '0;
    for (int g = 0; g < NG; g++) begin
      if (head[lams_pkg::F_DGRP +: GW] == GW'(g + 1)) begin
        grp_act = act_q[g*NP +: NP];
        grp_cnt = acnt_q[g*CW +: CW];
      end
    end
    // R01 pick depends only on flow fields and active set
    prod = cur_hash * grp_cnt;
    pick_idx = prod[lams_pkg::HASH_W +: CW];
    walk = '0;
    sel_port = head[lams_pkg::F_DPORT +: lams_pkg::PORT_W];
    sel_drop = head[lams_pkg::F_DGRP +: GW] != '0;
    // R17 walk active members only
    for (int p = 0; p < NP; p++) begin
      if (head[lams_pkg::F_DGRP +: GW] != '0 && grp_act[p]) begin
        if (walk == pick_idx && sel_drop) begin
          sel_port = lams_pkg::PORT_W'(p);
          sel_drop = 1'b0;
        end
        walk = walk + 1'b1;
      end
    end
  end

  // ****************************************
  // Output stage
  // ****************************************
  always_comb begin
    next_out_valid = out_valid && !out_ready;
    next_out_port = out_port;
    next_out_drop = out_drop;
    next_out_tag = out_tag;
    if (load_ev) begin
      next_out_valid = 1'b1;
      next_out_port = sel_port;
      next_out_drop = sel_drop;
      next_out_tag = head[lams_pkg::F_TAG +: lams_pkg::TAG_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_port <= '0;
      out_drop <= 1'b0;
      out_tag <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_port <= next_out_port;
      out_drop <= next_out_drop;
      out_tag <= next_out_tag;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic chk_limit;
  logic chk_onegrp;
  logic chk_dup;

  // Helpers scan registered membership
  always_comb begin
    logic [CW-1:0] c;
    logic [CW-1:0] a;
    logic [3:0] n;
    c = '0;
    a = '0;
    n = '0;
    chk_limit = 1'b1;
    chk_onegrp = 1'b1;
    chk_dup = 1'b1;
    for (int g = 0; g < NG; g++) begin
      c = '0;
      a = '0;
      for (int p = 0; p < NP; p++) begin
        c = c + CW'(mem_q[g*NP + p]);
        a = a + CW'(act_q[g*NP + p]);
      end
      if (c > CW'(MAXM) || (grp_lacp_cfg[g] && a > grp_max_active_cfg[g*CW +: CW])) begin
        chk_limit = 1'b0;
      end
    end
    for (int p = 0; p < NP; p++) begin
      n = '0;
      for (int g = 0; g < NG; g++) begin
        n = n + 4'(mem_q[g*NP + p]);
      end
      if (n > 4'h1) begin
        chk_onegrp = 1'b0;
      end
      if (member_active[p] && !port_full_duplex[p]) begin
        chk_dup = 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_smac_rst;
    disable iff (1'b0) sys_rst |=> hash_en[lams_pkg::HEN_SMAC] == 1'b1;
  endproperty
  a_smac_rst: assert property (p_smac_rst) else $error("source MAC enable not set after reset"); // R03
  property p_dmac_rst;
    disable iff (1'b0) sys_rst |=> hash_en[lams_pkg::HEN_DMAC] == 1'b0;
  endproperty
  a_dmac_rst: assert property (p_dmac_rst) else $error("destination MAC enable not clear after reset"); // R04
  property p_ip_rst;
    disable iff (1'b0) sys_rst |=> hash_en[lams_pkg::HEN_IP] == 1'b1;
  endproperty
  a_ip_rst: assert property (p_ip_rst) else $error("IP enable not set after reset"); // R05
  property p_l4_rst;
    disable iff (1'b0) sys_rst |=> hash_en[lams_pkg::HEN_L4] == 1'b1;
  endproperty
  a_l4_rst: assert property (p_l4_rst) else $error("L4 enable not set after reset"); // R06
  property p_hash_hold;
    !hash_cfg_we |=> $stable(hash_en);
  endproperty
  a_hash_hold: assert property (p_hash_hold) else $error("hash enables changed without a write"); // R07
  property p_hash_off;
    head_valid && hash_en == '0 |-> cur_hash == '0;
  endproperty
  a_hash_off: assert property (p_hash_off) else $error("disabled contributors still hashed"); // R02
  property p_same_flow;
    load_ev && $past(load_ev) && cur_hash == $past(cur_hash) && head[lams_pkg::F_DGRP +: GW] != '0
      && head[lams_pkg::F_DGRP +: GW] == $past(head[lams_pkg::F_DGRP +: GW]) && $stable(act_q)
      |=> out_port == $past(out_port) && out_drop == $past(out_drop);
  endproperty
  a_same_flow: assert property (p_same_flow) else $error("one flow left by two member ports"); // R01
  property p_limit;
    chk_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("group member or active ceiling exceeded"); // R08
  property p_one_grp;
    chk_onegrp;
  endproperty
  a_one_grp: assert property (p_one_grp) else $error("port in two groups"); // R10
  property p_mirror;
    ((mirror_src_en | mirror_dst_en) & member_mask) == '0;
  endproperty
  a_mirror: assert property (p_mirror) else $error("member port enabled for mirroring"); // R11
  property p_dup;
    chk_dup || !$stable(port_full_duplex);
  endproperty
  a_dup: assert property (p_dup) else $error("half duplex port active in group"); // R13
  property p_pick_active;
    load_ev && !sel_drop && head[lams_pkg::F_DGRP +: GW] != '0 |-> grp_act[sel_port] && grp_cnt != '0;
  endproperty
  a_pick_active: assert property (p_pick_active) else $error("frame sent to inactive member"); // R17

  c_group_frame: cover property (load_ev && head[lams_pkg::F_DGRP +: GW] != '0 && !sel_drop);
  c_drop: cover property (load_ev && sel_drop);
  c_standby: cover property (member_standby != '0);
  c_full: cover property (!in_ready);
endmodule

// ---- lams_partner.sv ----
// Purpose: Far-end switch model seen through the member port side
// Assumes: One clock; each frame is one out_valid/out_ready word
// Notes: Records every accepted word; stall and slow set its pace
`timescale 1ns/10ps
module lams_partner #(
  parameter int NP = 28
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic slow,
  input wire logic [NP-1:0] lacp_on,
  output logic [NP-1:0] partner_lacp,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [lams_pkg::PORT_W-1:0] out_port,
  input wire logic out_drop,
  input wire logic [lams_pkg::TAG_W-1:0] out_tag
);
  // ****************************************
  // Receive side
  // ****************************************
  logic [13:0] rx_q[$];
  logic phase = 1'b0;
  assign partner_lacp = lacp_on;
  // Slow mode accepts every other cycle to stretch the drain
  always @(posedge ref_clk) begin
    if (out_valid && out_ready && !sys_rst) begin
      rx_q.push_back({out_drop, out_port, out_tag});
    end
    phase <= ~phase;
    out_ready <= !sys_rst && !stall && (!slow || phase);
  end
endmodule

// ---- lams_tb_top.sv ----
// Purpose: Self-checking bench for the member selector
// Assumes: Expected ports come from a private copy of the hash recipe
// Notes: Hash enables change only with the pipeline empty
`timescale 1ns/10ps
module tb_top;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  localparam int NP = lams_pkg::NUM_PORTS;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hash_cfg_we = 1'b0;
  logic [3:0] hash_cfg_data = 4'h0;
  logic [NP*3-1:0] port_grp_cfg = '0;
  logic [4:0] grp_lacp_cfg = 5'h00;
  logic [19:0] grp_max_active_cfg = 20'h00000;
  logic [9:0] grp_speed_cfg = 10'h2aa;
  logic [NP-1:0] port_link_up = '1;
  logic [NP-1:0] port_full_duplex = '1;
  logic [NP*2-1:0] port_speed = {NP{2'h2}};
  logic [NP-1:0] mirror_src_req = '0, mirror_dst_req = '0, port_stp_fwd_cfg = '0, port_vlan_member_cfg = '0;
  logic [4:0] grp_stp_fwd = 5'h00, grp_vlan_member = 5'h00;
  logic in_valid = 1'b0, in_is_ipv4 = 1'b0, in_is_l4 = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [47:0] in_smac = '0, in_dmac = '0;
  logic [31:0] in_sip = '0, in_dip = '0;
  logic [15:0] in_sl4 = '0, in_dl4 = '0;
  logic [4:0] in_dst_port = 5'h00;
  logic [2:0] in_dst_grp = 3'h0;
  logic [7:0] in_tag = 8'h00, tag_n = 8'h00;
  logic [NP-1:0] lacp_on = '0, partner_lacp, member_mask, member_active, member_standby;
  logic [NP-1:0] mirror_src_en, mirror_dst_en, port_stp_fwd, port_vlan_member;
  logic [3:0] hash_en, hen = 4'hd;
  logic [4:0] grp_up, out_port;
  logic [7:0] out_tag;
  logic in_ready, out_valid, out_ready, out_drop, t;
  logic [14:0] exp_q[$];
  logic [3:0] modes [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'hd};
  int n_mismatch = 0, tests_run = 0, n;
  always #50 ref_clk = ~ref_clk;
  lams_top dut (.ref_clk, .sys_rst, .hash_cfg_we, .hash_cfg_data, .hash_en, .port_grp_cfg, .grp_lacp_cfg,
    .grp_max_active_cfg, .grp_speed_cfg, .port_link_up, .port_full_duplex, .port_speed, .partner_lacp,
    .mirror_src_req, .mirror_dst_req, .grp_stp_fwd, .port_stp_fwd_cfg, .grp_vlan_member, .port_vlan_member_cfg,
    .in_valid, .in_ready, .in_smac, .in_dmac, .in_sip, .in_dip, .in_sl4, .in_dl4, .in_is_ipv4, .in_is_l4,
    .in_dst_port, .in_dst_grp, .in_tag, .out_valid, .out_ready, .out_port, .out_drop, .out_tag, .member_mask,
    .member_active, .member_standby, .grp_up, .mirror_src_en, .mirror_dst_en, .port_stp_fwd, .port_vlan_member);
  lams_partner #(.NP(NP)) partner (.ref_clk, .sys_rst, .stall, .slow, .lacp_on, .partner_lacp, .out_valid,
    .out_ready, .out_port, .out_drop, .out_tag);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] hx(input logic [3:0] en, input logic [47:0] sm, dm, input logic [31:0] si, di,
      input logic [15:0] s4, d4, input logic v4, l4);
    logic [15:0] h;
    h = 16'h0000;
    if (en[lams_pkg::HEN_SMAC]) h ^= sm[15:0] ^ sm[31:16] ^ sm[47:32];
    if (en[lams_pkg::HEN_DMAC]) h ^= dm[15:0] ^ dm[31:16] ^ dm[47:32];
    if (en[lams_pkg::HEN_IP] && v4) h ^= si[15:0] ^ si[31:16] ^ di[15:0] ^ di[31:16];
    if (en[lams_pkg::HEN_L4] && v4 && l4) h ^= s4 ^ d4;
    return h[15:8] ^ h[7:0];
  endfunction
  // Group 2 has ports 15 and 16 active when frames go to it
  task automatic send(input logic [7:0] s, input logic [2:0] g, input logic [4:0] dp, input logic v4, l4);
    logic [47:0] sm, dm;
    logic [31:0] si, di;
    logic [15:0] s4, d4;
    logic [7:0] h;
    logic drop;
    sm = {s, 8'h12, s ^ 8'h5a, 8'h34, ~s, 8'h56};
    dm = {8'h9a, s, 8'hbc, s + 8'h03, 8'hde, s};
    si = {s, 8'h0a, ~s, 8'h01};
    di = {8'hc0, s ^ 8'hf0, 8'ha8, s};
    s4 = {s, 8'h50};
    d4 = {8'h01, s + 8'h07};
    h = hx(hen, sm, dm, si, di, s4, d4, v4, l4);
    drop = !(g == 3'h0 || g == 3'h2);
    exp_q.push_back({!drop, drop, (g == 3'h0) ? dp : 5'h0f + {4'h0, h[7]}, tag_n});
    in_smac <= sm;
    in_dmac <= dm;
    in_sip <= si;
    in_dip <= di;
    in_sl4 <= s4;
    in_dl4 <= d4;
    in_is_ipv4 <= v4;
    in_is_l4 <= l4;
    in_dst_grp <= g;
    in_dst_port <= dp;
    in_tag <= tag_n;
    in_valid <= 1'b1;
    tag_n++;
  endtask
  task automatic wait_take(input int lim, output logic took);
    took = 1'b0;
    for (int i = 0; i < lim && !took; i++) begin
      @(posedge ref_clk);
      took = (in_ready === 1'b1);
    end
  endtask
  task automatic xfer(input logic [7:0] s, input logic [2:0] g, input logic [4:0] dp, input logic v4, l4);
    logic tk;
    send(s, g, dp, v4, l4);
    wait_take(40, tk);
    check(tk, 1'b1);
  endtask
  task automatic drain_cmp;
    logic [14:0] e;
    logic [13:0] r;
    in_valid <= 1'b0;
    for (int i = 0; i < 300 && partner.rx_q.size() < exp_q.size(); i++) @(posedge ref_clk);
    // One more edge, so the last accept and its outputs have settled
    @(posedge ref_clk);
    check(partner.rx_q.size(), exp_q.size());
    while (exp_q.size() > 0 && partner.rx_q.size() > 0) begin
      e = exp_q.pop_front();
      r = partner.rx_q.pop_front();
      check({r[13], r[7:0]}, {e[13], e[7:0]});
      if (e[14]) check(r[12:8], e[12:8]);
    end
    exp_q.delete();
  endtask
  task automatic settle;
    repeat (2) @(posedge ref_clk);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check(hash_en, 4'hd);
    for (int p = 0; p < 12; p++) port_grp_cfg[3*p +: 3] <= 3'h1;
    port_grp_cfg[36 +: 3] <= 3'h6;
    for (int p = 14; p < 18; p++) port_grp_cfg[3*p +: 3] <= 3'h2;
    port_full_duplex <= 28'hffffffd;
    grp_lacp_cfg <= 5'h02;
    grp_max_active_cfg <= 20'h00020;
    lacp_on <= '1;
    mirror_src_req <= '1;
    mirror_dst_req <= 28'h0000fff;
    grp_stp_fwd <= 5'h01;
    port_vlan_member_cfg <= '1;
    settle;
    check(member_mask, 28'h003c3ff);
    check(member_active, 28'h000c3fd);
    check(member_standby, 28'h0030002);
    check(grp_up, 5'h03);
    check({mirror_src_en, mirror_dst_en}, {28'hffc3c00, 28'h0000c00});
    check({port_stp_fwd, port_vlan_member}, {28'h00003ff, 28'hffc3c00});
    lacp_on <= '0;
    settle;
    check({member_active, grp_up}, {28'h00003fd, 5'h01});
    lacp_on <= '1;
    port_link_up <= 28'hfffbfff;
    settle;
    check({member_active, member_standby}, {28'h00183fd, 28'h0024002});
    // Enables switch only with the pipeline empty, else queued frames mix modes
    foreach (modes[m]) begin
      hen = modes[m];
      hash_cfg_data <= hen;
      hash_cfg_we <= 1'b1;
      @(posedge ref_clk);
      hash_cfg_we <= 1'b0;
      @(posedge ref_clk);
      check(hash_en, hen);
      repeat (2) xfer(8'h11, 3'h2, 5'h00, 1'b1, 1'b1);
      xfer(8'h5e, 3'h2, 5'h00, 1'b1, 1'b0);
      repeat (2) xfer(8'hc7, 3'h2, 5'h00, 1'b0, 1'b0);
      xfer(8'h3a, 3'h0, 5'h05, 1'b1, 1'b1);
      xfer(8'h3b, 3'h3, 5'h00, 1'b1, 1'b1);
      xfer(8'h3c, 3'h7, 5'h00, 1'b1, 1'b1);
      drain_cmp;
    end
    stall <= 1'b1;
    n = 0;
    t = 1'b1;
    while (t && n < 24) begin
      send(n[7:0], 3'h2, 5'h00, 1'b1, 1'b1);
      wait_take(8, t);
      if (t) n++;
    end
    check(n >= 16 && n <= 18, 1'b1);
    slow <= 1'b1;
    stall <= 1'b0;
    wait_take(200, t);
    check(t, 1'b1);
    drain_cmp;
    check({in_ready, out_valid}, 2'h2);
    give_verdict;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict;
  end
endmodule
